/* src/pmx_pkg.sv */
// package: register map, field positions and reset values of the pin mux
package pmx_pkg;
    localparam int          AW          = 4;
    localparam int          DW          = 8;
    // register addresses
    localparam logic [3:0]  A_P5_DATA   = 4'h0;
    localparam logic [3:0]  A_P5_DIR    = 4'h1;
    localparam logic [3:0]  A_P5_PU     = 4'h2;
    localparam logic [3:0]  A_P6_DATA   = 4'h3;
    localparam logic [3:0]  A_P6_DIR    = 4'h4;
    localparam logic [3:0]  A_P6_PU     = 4'h5;
    localparam logic [3:0]  A_P7_DATA   = 4'h6;
    localparam logic [3:0]  A_P7_DIR    = 4'h7;
    localparam logic [3:0]  A_P7_PU     = 4'h8;
    localparam logic [3:0]  A_P7_MODE   = 4'h9;
    localparam logic [3:0]  A_P8_DATA   = 4'ha;
    localparam logic [3:0]  A_P9_DATA   = 4'hb;
    localparam logic [3:0]  A_FSEL      = 4'hc;
    localparam logic [3:0]  A_P12_CTL   = 4'hd;
    localparam logic [3:0]  A_LCD_CTL   = 4'he;
    // reset values (direction 1 means input) and the port six pull-up mask
    localparam logic [7:0]  DIR8_RST    = 8'hff;
    localparam logic [3:0]  DIR4_RST    = 4'hf;
    localparam logic [7:0]  P6_PU_MASK  = 8'hf0;
    // field positions
    localparam int          FSEL_P8_B   = 0;
    localparam int          FSEL_P9_B   = 1;
    localparam int          P12_OUT_B   = 0;
    localparam int          P12_DIR_B   = 1;
    localparam int          P12_PU_B    = 2;
    localparam int          LCD_STAT_B  = 0;
    localparam int          P7_T4_CLK_B = 1;
    localparam int          P7_T52_CLK_B = 3;
    // segment grouping
    localparam int          SEG_STAT_N  = 12;
    localparam int          SEG_DIR_N   = 24;
    localparam int          SEG_P9_LO   = 24;
    localparam int          SEG_P8_LO   = 32;
    localparam int          SEG_N       = 40;
endpackage : pmx_pkg

/* src/pmx_pin_mux.sv */
// module: port 5/6/7/8/9/12 pin control and lcd segment/common pin routing
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - port five, per-bit direction and pull-up
// - port six, per-bit direction
// - port six pull-ups only on upper four
// - port seven, per-bit direction and pull-up
// - port seven carries timer clocks and outputs
// - port eight selects latch or segments 32-39
// - port nine selects latch or segments 24-31
// - function select switches whole eight-pin group
// - port twelve, direction and pull-up bits
// - segments 0-11 static or dynamic, rest dynamic
// - four dynamic commons, one static common
// - low reset input resets the block
module pmx_pin_mux (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  p5_in,
    output logic      [7:0]  p5_out,
    output logic      [7:0]  p5_oe,
    output logic      [7:0]  p5_pullup_en,
    input  wire logic [7:0]  p6_in,
    output logic      [7:0]  p6_out,
    output logic      [7:0]  p6_oe,
    output logic      [7:0]  p6_pullup_en,
    input  wire logic [3:0]  p7_in,
    output logic      [3:0]  p7_out,
    output logic      [3:0]  p7_oe,
    output logic      [3:0]  p7_pullup_en,
    output logic      [7:0]  p8_out,
    output logic      [7:0]  p9_out,
    input  wire logic        p12_in,
    output logic             p12_out,
    output logic             p12_oe,
    output logic             p12_pullup_en,
    input  wire logic        timer4_output,
    input  wire logic        timer52_output,
    output logic             timer4_count_clock_in,
    output logic             timer52_count_clock_in,
    input  wire logic [39:0] lcd_dyn_seg,
    input  wire logic [11:0] lcd_static_seg,
    input  wire logic [3:0]  lcd_dyn_com,
    input  wire logic        lcd_static_com,
    output logic      [23:0] segment_outputs,
    output logic      [3:0]  dynamic_common_outputs,
    output logic             static_common_output
);

    typedef struct packed {
        logic [7:0]  p5_latch;
        logic [7:0]  port5_direction_reg;
        logic [7:0]  port5_pullup_reg;
        logic [7:0]  p6_latch;
        logic [7:0]  port6_direction_reg;
        logic [7:0]  port6_pullup_reg;
        logic [3:0]  p7_latch;
        logic [3:0]  port7_direction_reg;
        logic [3:0]  port7_pullup_reg;
        logic [3:0]  p7_ctl_mode;
        logic [7:0]  p8_latch;
        logic [7:0]  p9_latch;
        logic        port8_function_select;
        logic        port9_function_select;
        logic        p12_latch;
        logic        port12_direction_reg;
        logic        port12_pullup_reg;
        logic        lcd_static;
        logic [7:0]  rdata;
        logic [7:0]  p5_o;
        logic [7:0]  p5_e;
        logic [7:0]  p5_u;
        logic [7:0]  p6_o;
        logic [7:0]  p6_e;
        logic [7:0]  p6_u;
        logic [3:0]  p7_o;
        logic [3:0]  p7_e;
        logic [3:0]  p7_u;
        logic [7:0]  p8_o;
        logic [7:0]  p9_o;
        logic        p12_o;
        logic        p12_e;
        logic        p12_u;
        logic        t4_clk;
        logic        t52_clk;
        logic [23:0] seg_o;
        logic [3:0]  com_o;
        logic        scom_o;
    } pmx_state_s;

    pmx_state_s r;
    pmx_state_s next_r;
    logic [3:0] p7_alt;

    // timer outputs sit on pins 0 and 2 of port seven
    assign p7_alt = {1'b0, timer52_output, 1'b0, timer4_output};

    // register writes, reads, pin drive and reset
    always_comb begin
        next_r       = r;
        next_r.rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                pmx_pkg::A_P5_DATA: next_r.p5_latch            = reg_wdata;
                pmx_pkg::A_P5_DIR:  next_r.port5_direction_reg = reg_wdata;
                pmx_pkg::A_P5_PU:   next_r.port5_pullup_reg    = reg_wdata;
                pmx_pkg::A_P6_DATA: next_r.p6_latch            = reg_wdata;
                pmx_pkg::A_P6_DIR:  next_r.port6_direction_reg = reg_wdata;
                pmx_pkg::A_P6_PU:   next_r.port6_pullup_reg    =
                    reg_wdata & pmx_pkg::P6_PU_MASK;
                pmx_pkg::A_P7_DATA: next_r.p7_latch            = reg_wdata[3:0];
                pmx_pkg::A_P7_DIR:  next_r.port7_direction_reg = reg_wdata[3:0];
                pmx_pkg::A_P7_PU:   next_r.port7_pullup_reg    = reg_wdata[3:0];
                pmx_pkg::A_P7_MODE: next_r.p7_ctl_mode         = reg_wdata[3:0];
                pmx_pkg::A_P8_DATA: next_r.p8_latch            = reg_wdata;
                pmx_pkg::A_P9_DATA: next_r.p9_latch            = reg_wdata;
                pmx_pkg::A_FSEL: begin // one bit per whole group
                    next_r.port8_function_select = reg_wdata[pmx_pkg::FSEL_P8_B];
                    next_r.port9_function_select = reg_wdata[pmx_pkg::FSEL_P9_B];
                end
                pmx_pkg::A_P12_CTL: begin
                    next_r.p12_latch            = reg_wdata[pmx_pkg::P12_OUT_B];
                    next_r.port12_direction_reg = reg_wdata[pmx_pkg::P12_DIR_B];
                    next_r.port12_pullup_reg    = reg_wdata[pmx_pkg::P12_PU_B];
                end
                pmx_pkg::A_LCD_CTL: next_r.lcd_static = reg_wdata[pmx_pkg::LCD_STAT_B];
                default: ;
            endcase
        end
        // data reads return the pin for input bits and the latch for output bits
        if (reg_rd) begin
            case (reg_addr)
                pmx_pkg::A_P5_DATA: next_r.rdata = (p5_in & r.port5_direction_reg)
                                                 | (r.p5_latch & ~r.port5_direction_reg);
                pmx_pkg::A_P5_DIR:  next_r.rdata = r.port5_direction_reg;
                pmx_pkg::A_P5_PU:   next_r.rdata = r.port5_pullup_reg;
                pmx_pkg::A_P6_DATA: next_r.rdata = (p6_in & r.port6_direction_reg)
                                                 | (r.p6_latch & ~r.port6_direction_reg);
                pmx_pkg::A_P6_DIR:  next_r.rdata = r.port6_direction_reg;
                pmx_pkg::A_P6_PU:   next_r.rdata = r.port6_pullup_reg;
                pmx_pkg::A_P7_DATA: next_r.rdata = {4'h0, (p7_in & r.port7_direction_reg)
                                                 | (r.p7_latch & ~r.port7_direction_reg)};
                pmx_pkg::A_P7_DIR:  next_r.rdata = {4'h0, r.port7_direction_reg};
                pmx_pkg::A_P7_PU:   next_r.rdata = {4'h0, r.port7_pullup_reg};
                pmx_pkg::A_P7_MODE: next_r.rdata = {4'h0, r.p7_ctl_mode};
                pmx_pkg::A_P8_DATA: next_r.rdata = r.p8_latch;
                pmx_pkg::A_P9_DATA: next_r.rdata = r.p9_latch;
                pmx_pkg::A_FSEL:    next_r.rdata = {6'h00, r.port9_function_select,
                                                    r.port8_function_select};
                pmx_pkg::A_P12_CTL: next_r.rdata = {5'h00, r.port12_pullup_reg,
                    r.port12_direction_reg,
                    r.port12_direction_reg ? p12_in : r.p12_latch};
                pmx_pkg::A_LCD_CTL: next_r.rdata = {7'h00, r.lcd_static};
                default:            next_r.rdata = '0;
            endcase
        end
        // synchronous low-active reset: all ports input, pull-ups off
        if (!nrst) begin
            next_r                      = '0;
            next_r.port5_direction_reg  = pmx_pkg::DIR8_RST;
            next_r.port6_direction_reg  = pmx_pkg::DIR8_RST;
            next_r.port7_direction_reg  = pmx_pkg::DIR4_RST;
            next_r.port12_direction_reg = 1'b1;
        end
        // port five: plain push-pull, pull-up only while input
        next_r.p5_o = next_r.p5_latch;
        next_r.p5_e = ~next_r.port5_direction_reg;
        next_r.p5_u = next_r.port5_pullup_reg & next_r.port5_direction_reg;
        // port six: lower nibble open-drain, drives low only
        next_r.p6_o = next_r.p6_latch & pmx_pkg::P6_PU_MASK;
        next_r.p6_e = ~next_r.port6_direction_reg
                    & (pmx_pkg::P6_PU_MASK | ~next_r.p6_latch);
        next_r.p6_u = next_r.port6_pullup_reg & next_r.port6_direction_reg
                    & pmx_pkg::P6_PU_MASK;
        // port seven: control mode puts timer outputs on the pins
        next_r.p7_o = (next_r.p7_ctl_mode & p7_alt)
                    | (~next_r.p7_ctl_mode & next_r.p7_latch);
        next_r.p7_e = ~next_r.port7_direction_reg;
        next_r.p7_u = next_r.port7_pullup_reg & next_r.port7_direction_reg;
        // timer count clocks pass only in control mode
        next_r.t4_clk  = next_r.p7_ctl_mode[pmx_pkg::P7_T4_CLK_B]
                       & p7_in[pmx_pkg::P7_T4_CLK_B];
        next_r.t52_clk = next_r.p7_ctl_mode[pmx_pkg::P7_T52_CLK_B]
                       & p7_in[pmx_pkg::P7_T52_CLK_B];
        // ports eight and nine: segment drive replaces the latch per group
        next_r.p8_o = next_r.port8_function_select
                    ? lcd_dyn_seg[pmx_pkg::SEG_P8_LO +: 8] : next_r.p8_latch;
        next_r.p9_o = next_r.port9_function_select
                    ? lcd_dyn_seg[pmx_pkg::SEG_P9_LO +: 8] : next_r.p9_latch;
        // port twelve: dac use relies on software setting input, no pull-up
        next_r.p12_o = next_r.p12_latch;
        next_r.p12_e = ~next_r.port12_direction_reg;
        next_r.p12_u = next_r.port12_pullup_reg & next_r.port12_direction_reg;
        // dedicated segments: only the low twelve may run static
        next_r.seg_o = lcd_dyn_seg[pmx_pkg::SEG_DIR_N-1:0];
        if (next_r.lcd_static) begin
            next_r.seg_o[pmx_pkg::SEG_STAT_N-1:0] = lcd_static_seg;
        end
        next_r.com_o  = lcd_dyn_com;
        next_r.scom_o = lcd_static_com;
    end

    // state register
    always_ff @(posedge core_clk) begin
        r <= next_r;
    end

    // outputs straight from the state flops
    assign reg_rdata              = r.rdata;
    assign p5_out                 = r.p5_o;
    assign p5_oe                  = r.p5_e;
    assign p5_pullup_en           = r.p5_u;
    assign p6_out                 = r.p6_o;
    assign p6_oe                  = r.p6_e;
    assign p6_pullup_en           = r.p6_u;
    assign p7_out                 = r.p7_o;
    assign p7_oe                  = r.p7_e;
    assign p7_pullup_en           = r.p7_u;
    assign p8_out                 = r.p8_o;
    assign p9_out                 = r.p9_o;
    assign p12_out                = r.p12_o;
    assign p12_oe                 = r.p12_e;
    assign p12_pullup_en          = r.p12_u;
    assign timer4_count_clock_in  = r.t4_clk;
    assign timer52_count_clock_in = r.t52_clk;
    assign segment_outputs        = r.seg_o;
    assign dynamic_common_outputs = r.com_o;
    assign static_common_output   = r.scom_o;

    // checks on register-to-pin behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_P5_DIR_OE: assert property (
        reg_wr && reg_addr == pmx_pkg::A_P5_DIR |=> p5_oe == ~$past(reg_wdata))
        else $error("port five enable does not follow direction write");
    AST_P5_PU: assert property (
        reg_wr && reg_addr == pmx_pkg::A_P5_PU
        |=> p5_pullup_en == ($past(reg_wdata) & ~p5_oe))
        else $error("port five pull-up active on an output bit");
    AST_P6_DIR_OE: assert property (
        reg_wr && reg_addr == pmx_pkg::A_P6_DIR && reg_wdata[7:4] == 4'h0
        |=> p6_oe[7:4] == 4'hf)
        else $error("port six upper pins not driven after output select");
    AST_P6_LOW_PU: assert property (
        reg_wr && reg_addr == pmx_pkg::A_P6_PU |=> p6_pullup_en[3:0] == 4'h0)
        else $error("port six lower pins got a pull-up");
    AST_P7_OE: assert property (
        reg_wr && reg_addr == pmx_pkg::A_P7_DIR |=> p7_oe == ~$past(reg_wdata[3:0]))
        else $error("port seven enable does not follow direction write");
    AST_T4_CLK: assert property (
        nrst && r.p7_ctl_mode[pmx_pkg::P7_T4_CLK_B] && !reg_wr
        |=> timer4_count_clock_in == $past(p7_in[pmx_pkg::P7_T4_CLK_B]))
        else $error("timer four clock not forwarded");
    AST_P8_SEG: assert property (
        nrst && r.port8_function_select && !reg_wr
        |=> p8_out == $past(lcd_dyn_seg[pmx_pkg::SEG_P8_LO +: 8]))
        else $error("port eight does not carry segment drive");
    AST_P9_PORT: assert property (
        nrst && !r.port9_function_select && !reg_wr ##1 !reg_wr
        |=> p9_out == $past(r.p9_latch, 2))
        else $error("port nine does not carry latch data");
    AST_P12_CTL: assert property (
        reg_wr && reg_addr == pmx_pkg::A_P12_CTL |=> p12_oe == !$past(reg_wdata[1]))
        else $error("port twelve enable does not follow direction write");
    AST_SEG_STATIC: assert property (
        nrst && r.lcd_static && !reg_wr
        |=> segment_outputs[23:12] == $past(lcd_dyn_seg[23:12])
        && segment_outputs[11:0] == $past(lcd_static_seg))
        else $error("segment static routing wrong");
    AST_COM: assert property (
        1'b1 |=> dynamic_common_outputs == $past(lcd_dyn_com))
        else $error("dynamic commons not passed");
    AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
        !nrst |=> p5_oe == 8'h00 && p12_pullup_en == 1'b0 && p8_out == 8'h00)
        else $error("reset did not return pins to input");

    COV_P8_SEG: cover property (reg_wr && reg_addr == pmx_pkg::A_FSEL ##1 r.port8_function_select);
    COV_P7_CTL: cover property (r.p7_ctl_mode == 4'hf ##1 timer52_count_clock_in);
    COV_P5_RD: cover property (reg_rd && reg_addr == pmx_pkg::A_P5_DATA);

endmodule : pmx_pin_mux

`default_nettype wire

/* verif/pmx_pin_model.sv */
// partner model: board-side level seen on one port's pins
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_model #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pin
);
    logic [W-1:0] flt = '0;  // level of an undriven pin without pull-up
    // a floating pin wanders every cycle so it never reads as a stable value
    always_ff @(posedge core_clk) begin
        flt <= ~flt;
    end
    // device drive wins, then board drive, then pull-up, else float
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : flt[i];
        end
    end
endmodule : pmx_pin_model
`default_nettype wire

/* verif/pmx_pin_mux_test.sv */
// testbench: register bus, port pins, timer and segment routing of the pin mux
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_mux_test;
    logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, rdv;
    logic [7:0]  p5_in, p5_out, p5_oe, p5_pu, p6_in, p6_out, p6_oe, p6_pu, p8_out, p9_out;
    logic [3:0]  p7_in, p7_out, p7_oe, p7_pu, dcom;
    logic        p12_in, p12_out, p12_oe, p12_pu, t4o = 1'b0, t52o = 1'b0, t4c, t52c, scom;
    logic [7:0]  e5 = 8'h5a, e6 = 8'h00, en5 = 8'hff, en6 = 8'h00;
    logic [3:0]  e7 = 4'h0, en7 = 4'ha, com_in = 4'h9;
    logic        e12 = 1'b1, en12 = 1'b1, scom_in = 1'b1;
    logic [39:0] dyn = 40'h3c96a55af0;
    logic [11:0] stat = 12'h2d1;
    logic [23:0] seg;
    int          errors = 0, n_tests = 0;
    always #2.5 core_clk = ~core_clk;
    // device under test
    pmx_pin_mux pmx_pin_mux_i (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .p5_in(p5_in), .p5_out(p5_out), .p5_oe(p5_oe), .p5_pullup_en(p5_pu),
        .p6_in(p6_in), .p6_out(p6_out), .p6_oe(p6_oe), .p6_pullup_en(p6_pu),
        .p7_in(p7_in), .p7_out(p7_out), .p7_oe(p7_oe), .p7_pullup_en(p7_pu),
        .p8_out(p8_out), .p9_out(p9_out), .p12_in(p12_in), .p12_out(p12_out),
        .p12_oe(p12_oe), .p12_pullup_en(p12_pu), .timer4_output(t4o),
        .timer52_output(t52o), .timer4_count_clock_in(t4c), .timer52_count_clock_in(t52c),
        .lcd_dyn_seg(dyn), .lcd_static_seg(stat), .lcd_dyn_com(com_in),
        .lcd_static_com(scom_in),
        .segment_outputs(seg), .dynamic_common_outputs(dcom), .static_common_output(scom));
    // board pins of each bidirectional port
    pmx_pin_model #(.W(8)) pmx_pin_model_p5_i (.core_clk(core_clk), .out(p5_out), .oe(p5_oe),
        .pu(p5_pu), .ext(e5), .ext_en(en5), .pin(p5_in));
    pmx_pin_model #(.W(8)) pmx_pin_model_p6_i (.core_clk(core_clk), .out(p6_out), .oe(p6_oe),
        .pu(p6_pu), .ext(e6), .ext_en(en6), .pin(p6_in));
    pmx_pin_model #(.W(4)) pmx_pin_model_p7_i (.core_clk(core_clk), .out(p7_out), .oe(p7_oe),
        .pu(p7_pu), .ext(e7), .ext_en(en7), .pin(p7_in));
    pmx_pin_model #(.W(1)) pmx_pin_model_p12_i (.core_clk(core_clk), .out(p12_out),
        .oe(p12_oe), .pu(p12_pu), .ext(e12), .ext_en(en12), .pin(p12_in));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask : rd
    task automatic t_reset;
        chk({p5_oe, p6_oe, p7_oe, p12_oe}, 0, "oe in reset");
        chk({p5_pu, p6_pu, p7_pu, p12_pu, p8_out, p9_out}, 0, "pu and out in reset");
        rd(pmx_pkg::A_P5_DIR, 8'hff, "p5 dir");
        rd(pmx_pkg::A_P6_DIR, 8'hff, "p6 dir");
        rd(pmx_pkg::A_P7_DIR, 8'h0f, "p7 dir");
        rd(pmx_pkg::A_P12_CTL, 8'h03, "p12 ctl");
        $display("test reset done");
    endtask : t_reset
    task automatic t_p5;
        wr(pmx_pkg::A_P5_DIR, 8'h0f);
        wr(pmx_pkg::A_P5_DATA, 8'ha5);
        wr(pmx_pkg::A_P5_PU, 8'hff);
        tick(1);
        chk(p5_oe, 8'hf0, "p5 oe");
        chk(p5_out & 8'hf0, 8'ha0, "p5 out");
        chk(p5_pu, 8'h0f, "p5 pullup");
        rd(pmx_pkg::A_P5_DATA, 8'haa, "p5 pins");
        $display("test port5 done");
    endtask : t_p5
    task automatic t_p6;
        @(posedge core_clk);
        e6 <= 8'h3c;
        en6 <= 8'hff;
        wr(pmx_pkg::A_P6_PU, 8'hff);
        tick(1);
        chk(p6_pu, 8'hf0, "p6 pullup");
        rd(pmx_pkg::A_P6_PU, 8'hf0, "p6 pullup reg");
        rd(pmx_pkg::A_P6_DATA, 8'h3c, "p6 input pins");
        wr(pmx_pkg::A_P6_DIR, 8'h00);
        wr(pmx_pkg::A_P6_DATA, 8'h35);
        tick(1);
        chk(p6_oe, 8'hfa, "p6 oe");
        chk(p6_out, 8'h30, "p6 out");
        chk(p6_pu, 8'h00, "p6 pullup output");
        $display("test port6 done");
    endtask : t_p6
    task automatic t_p7;
        @(posedge core_clk);
        e7 <= 4'h2;
        tick(2);
        chk(t4c, 1'b0, "t4 clk in port mode");
        wr(pmx_pkg::A_P7_DIR, 8'h0a);
        wr(pmx_pkg::A_P7_PU, 8'hff);
        wr(pmx_pkg::A_P7_MODE, 8'h0f);
        t4o <= 1'b1;
        tick(2);
        chk(p7_oe, 4'h5, "p7 oe");
        chk(p7_pu, 4'ha, "p7 pullup");
        chk({p7_out[2], p7_out[0], t52c, t4c}, 4'h5, "timers a");
        @(posedge core_clk);
        e7 <= 4'h8;
        t4o <= 1'b0;
        t52o <= 1'b1;
        tick(2);
        chk({p7_out[2], p7_out[0], t52c, t4c}, 4'ha, "timers b");
        $display("test port7 done");
    endtask : t_p7
    task automatic t_p89;
        wr(pmx_pkg::A_P8_DATA, 8'hc3);
        wr(pmx_pkg::A_P9_DATA, 8'h69);
        for (int f = 0; f < 4; f++) begin
            wr(pmx_pkg::A_FSEL, 8'(f));
            tick(1);
            chk(p8_out, f[0] ? dyn[39:32] : 8'hc3, "p8 pins");
            chk(p9_out, f[1] ? dyn[31:24] : 8'h69, "p9 pins");
        end
        $display("test port8 port9 done");
    endtask : t_p89
    task automatic t_p12;
        @(posedge core_clk);
        en12 <= 1'b0;
        wr(pmx_pkg::A_P12_CTL, 8'h06);
        tick(1);
        chk({p12_oe, p12_pu}, 2'b01, "p12 input pullup");
        rd(pmx_pkg::A_P12_CTL, 8'h07, "p12 pin via pullup");
        wr(pmx_pkg::A_P12_CTL, 8'h02);
        tick(1);
        chk({p12_oe, p12_pu}, 2'b00, "p12 released");
        wr(pmx_pkg::A_P12_CTL, 8'h01);
        tick(1);
        chk({p12_oe, p12_out, p12_pu}, 3'b110, "p12 output");
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00, "unmapped read");
        tick(1);
        chk(reg_rdata, 8'h00, "rdata after read");
        rd(pmx_pkg::A_P5_DIR, 8'h0f, "p5 dir kept");
        $display("test port12 done");
    endtask : t_p12
    task automatic t_lcd;
        chk(seg, dyn[23:0], "dynamic segs");
        chk({dcom, scom}, 5'h13, "commons");
        wr(pmx_pkg::A_LCD_CTL, 8'h01);
        tick(1);
        chk(seg, {dyn[23:12], stat}, "static segs");
        @(posedge core_clk);
        dyn <= 40'hc3695aa50f;
        stat <= 12'hd2e;
        com_in <= 4'h6;
        scom_in <= 1'b0;
        tick(1);
        chk(seg, {dyn[23:12], stat}, "static segs new");
        chk({dcom, scom}, 5'h0c, "commons new");
        chk({p8_out, p9_out}, dyn[39:24], "segment ports new");
        $display("test lcd done");
    endtask : t_lcd
    task automatic t_rst2;
        @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk({p5_oe, p8_out}, 0, "mid-run reset");
        chk(seg, dyn[23:0], "segs after reset");
        rd(pmx_pkg::A_P5_DIR, 8'hff, "p5 dir after reset");
        $display("test second reset done");
    endtask : t_rst2
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // main sequence: reset for two cycles, then each scenario in turn
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        t_reset();
        t_p5();
        t_p6();
        t_p7();
        t_p89();
        t_p12();
        t_lcd();
        t_rst2();
        wrap_up();
    end
    // watchdog: the run needs well under a thousand cycles
    initial begin
        #20000;
        errors++;
        wrap_up();
    end
endmodule : pmx_pin_mux_test
`default_nettype wire
